// ==== hw/sac_ctrl.sv ====
/*
 * sac_ctrl: digital control around a 12-bit sar converter: registers,
 * start selection, track/convert sequencing, result formatting and the
 * window detector. Assumes timer overflows are one-cycle pulses on the
 * same clock, adc_data_i is settled when the last sar clock of a
 * conversion arrives, and the start pin is asynchronous.
 */
`timescale 1ns/100ps
// What this block does
// - nonzero divide gives period two times (n+1)
// - zero divide runs sar at system rate
// - gain field decodes to 1,2,4,8,16,0.5
// - enable bit low holds converter shut down
// - continuous tracking except while converting
// - done flag sticky until software clears it
// - done flag rises as busy falls
// - busy reads one while converting
// - busy write one starts in mode 00
// - start mode picks the trigger source
// - low-power busy and timer starts track three sar clocks first
// - low-power pin mode tracks while pin low
// - window flag sticky until software clears
// - right justify with sign or zero fill
// - left justify, low nibble reads zero
// - unsigned single-ended, two's complement differential
// - compare every result against both limits
// - limit order selects inside or outside window
// - limit words built from high and low bytes
// - control bits writable by bit address
// - conversion lasts sixteen sar clocks
module sac_ctrl
	import sac_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rstn_i,
	// special function register bus
	input  wire logic [7:0]  sfr_page_i,
	input  wire logic [7:0]  sfr_addr_i,
	input  wire logic        sfr_wr_i,
	input  wire logic        sfr_rd_i,
	input  wire logic [7:0]  sfr_wdata_i,
	input  wire logic        sfr_bit_wr_i,
	input  wire logic [2:0]  sfr_bit_sel_i,
	input  wire logic        sfr_bit_val_i,
	output logic [7:0]       sfr_rdata_o,
	// start sources
	input  wire logic        timer3_ovf_i,
	input  wire logic        timer2_ovf_i,
	input  wire logic        ext_start_pin_i,
	// analog converter side
	input  wire logic [11:0] adc_data_i,
	input  wire logic        diff_mode_i,
	output logic             adc_enable_o,
	output logic             track_o,
	output logic             conv_active_o,
	output logic             sar_tick_o,
	output logic [2:0]       amp_gain_o,
	// flags
	output logic             conv_done_flag_o,
	output logic             window_match_flag_o
);
	typedef struct packed {
		logic [7:0] cfg;     // divide and gain
		logic [7:0] res_lo;  // result low byte
		logic [7:0] res_hi;  // result high byte
		logic [7:0] gth;     // upper limit high byte
		logic [7:0] gtl;     // upper limit low byte
		logic [7:0] lth;     // lower limit high byte
		logic [7:0] ltl;     // lower limit low byte
		logic       en;      // converter enable
		logic       tm;      // low-power track mode
		logic       done;    // conversion complete flag
		logic       busy;    // conversion in progress
		logic [1:0] cm;      // start mode
		logic       wint;    // window match flag
		logic       ljst;    // left justify
		sac_state_t st;      // sequencer state
		logic [4:0] cnt;     // sar clocks in the phase
		logic       pin_s1;  // start pin sync stage one
		logic       pin_s2;  // start pin sync stage two
		logic       pin_d;   // delayed synced pin for edges
		logic [7:0] rdata;   // registered read data
		logic       track;   // track output
		logic [2:0] gain;    // decoded gain output
		logic       active;  // converting output
	} sac_regs_t;

	sac_regs_t   s_r;
	sac_regs_t   n;
	logic        sar_tick;   // sar clock enable
	logic        restart;    // realign the sar clock
	logic        hit;        // access to page 0
	logic        ctl_wr;     // control written this cycle
	logic [7:0]  mask;       // control bits touched
	logic [7:0]  wval;       // control write value
	logic [7:0]  ctl_new;    // control after the write
	logic        go_sw;      // busy bit start request
	logic        go_tmr;     // timer start request
	logic        pin_rise;   // synced start pin edge
	logic        start;      // any accepted start
	logic        cmpl;       // conversion completes now
	logic        done_clr;   // software clears done
	logic        wint_clr;   // software clears window flag
	logic [15:0] word;       // formatted result
	logic        win_now;    // window match on this result

	// decode the gain field
	function automatic logic [2:0] gain_dec(input logic [2:0] g);
		case (g)
			3'h0: gain_dec = GAIN_X1;
			3'h1: gain_dec = GAIN_X2;
			3'h2: gain_dec = GAIN_X4;
			3'h3: gain_dec = GAIN_X8;
			3'h4, 3'h5: gain_dec = GAIN_X16;
			default: gain_dec = GAIN_X0P5;
		endcase
	endfunction

	// place a 12-bit code into the 16-bit data word
	function automatic logic [15:0] fmt(input logic [11:0] d,
		input logic dif, input logic lj);
		if (lj) begin
			fmt = {d, 4'h0};
		end else begin
			fmt = {dif ? {4{d[11]}} : 4'h0, d};
		end
	endfunction

	// window test; limit order picks inside or outside
	function automatic logic win_hit(input logic [15:0] w,
		input logic [15:0] gt, input logic [15:0] lt, input logic sg);
		logic above;
		logic below;
		logic inner;
		above = sg ? ($signed(w) > $signed(gt)) : (w > gt);
		below = sg ? ($signed(w) < $signed(lt)) : (w < lt);
		inner = sg ? ($signed(lt) > $signed(gt)) : (lt > gt);
		win_hit = inner ? (above & below) : (above | below);
	endfunction

	// sar clock divider
	sac_sar_div u_div (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.div_i     (s_r.cfg[7:3]),
		.restart_i (restart),
		.tick_o    (sar_tick)
	);

	// next state: bus, triggers, sequencer, results
	always_comb begin
		n = s_r;
		restart = 1'b0;
		start = 1'b0;
		cmpl = 1'b0;
		// two-stage synchroniser, then edge detector on stage two
		n.pin_s1 = ext_start_pin_i;
		n.pin_s2 = s_r.pin_s1;
		n.pin_d = s_r.pin_s2;
		pin_rise = s_r.pin_s2 & ~s_r.pin_d;
		hit = (sfr_page_i == SFR_PAGE_ADC);
		// byte writes to plain registers
		if (sfr_wr_i && hit) begin
			case (sfr_addr_i)
				ADDR_CFG:     n.cfg = sfr_wdata_i;
				ADDR_RES_LO:  n.res_lo = sfr_wdata_i;
				ADDR_RES_HI:  n.res_hi = sfr_wdata_i;
				ADDR_UL_LOW:  n.gtl = sfr_wdata_i;
				ADDR_UL_HIGH: n.gth = sfr_wdata_i;
				ADDR_LL_LOW:  n.ltl = sfr_wdata_i;
				ADDR_LL_HIGH: n.lth = sfr_wdata_i;
				default:      n.cfg = s_r.cfg;
			endcase
		end
		// control: byte write or single bit write
		ctl_wr = hit && (sfr_bit_wr_i ||
			(sfr_wr_i && sfr_addr_i == ADDR_CTL));
		mask = sfr_bit_wr_i ? 8'(8'h01 << sfr_bit_sel_i) : 8'hff;
		wval = sfr_bit_wr_i ? {8{sfr_bit_val_i}} : sfr_wdata_i;
		ctl_new = ({s_r.en, s_r.tm, s_r.done, s_r.busy, s_r.cm,
			s_r.wint, s_r.ljst} & ~mask) | (wval & mask);
		done_clr = ctl_wr && mask[CTL_DONE] && !wval[CTL_DONE];
		wint_clr = ctl_wr && mask[CTL_WINT] && !wval[CTL_WINT];
		if (ctl_wr) begin
			n.en = ctl_new[CTL_EN];
			n.tm = ctl_new[CTL_TM];
			n.done = ctl_new[CTL_DONE];
			n.cm = ctl_new[CTL_CMH:CTL_CML];
			n.wint = ctl_new[CTL_WINT];
			n.ljst = ctl_new[CTL_LJST];
		end
		// start requests; writing zero to busy does nothing
		go_sw = ctl_wr && mask[CTL_BUSY] && wval[CTL_BUSY] &&
			n.cm == SM_BUSY_WR;
		go_tmr = (n.cm == SM_TIMER3 && timer3_ovf_i) ||
			(n.cm == SM_TIMER2 && timer2_ovf_i);
		word = fmt(adc_data_i, diff_mode_i, n.ljst);
		win_now = win_hit(word, {n.gth, n.gtl}, {n.lth, n.ltl},
			diff_mode_i);
		// sequencer
		case (s_r.st)
			ST_IDLE: begin
				if (n.en && (go_sw || go_tmr)) begin
					// busy or timer start: track first in low-power mode
					start = 1'b1;
					n.st = n.tm ? ST_TRACK : ST_CONV;
				end else if (n.en && n.cm == SM_EXT_PIN && pin_rise) begin
					// pin edge ends tracking and converts
					start = 1'b1;
					n.st = ST_CONV;
				end
				if (start) begin
					n.busy = 1'b1;
					n.cnt = 5'h00;
					restart = 1'b1;
				end
			end
			ST_TRACK: begin
				// three sar clocks of tracking
				if (sar_tick && s_r.cnt == TRACK_LAST) begin
					n.st = ST_CONV;
					n.cnt = 5'h00;
					restart = 1'b1;
				end else if (sar_tick) begin
					n.cnt = s_r.cnt + 5'h01;
				end
			end
			ST_CONV: begin
				// sixteen sar clocks of conversion
				if (sar_tick && s_r.cnt == CONV_LAST) begin
					cmpl = 1'b1;
				end else if (sar_tick) begin
					n.cnt = s_r.cnt + 5'h01;
				end
			end
			default: n.st = ST_IDLE;
		endcase
		if (cmpl) begin
			// results, busy fall, flags; set wins over clear
			n.st = ST_IDLE;
			n.busy = 1'b0;
			n.done = 1'b1;
			n.res_hi = word[15:8];
			n.res_lo = word[7:0];
			if (win_now) begin
				n.wint = 1'b1;
			end
		end else if (!n.en) begin
			// shutdown aborts any sequence
			n.st = ST_IDLE;
			n.busy = 1'b0;
		end
		// analog side controls
		if (!n.en) begin
			n.track = 1'b0;
		end else if (!n.tm) begin
			n.track = (n.st != ST_CONV);
		end else if (n.cm == SM_EXT_PIN) begin
			n.track = (n.st == ST_IDLE) && !s_r.pin_s2;
		end else begin
			n.track = (n.st == ST_TRACK);
		end
		n.gain = gain_dec(n.cfg[2:0]);
		n.active = (n.st == ST_CONV);
		// registered read data; unmapped reads give zero
		if (sfr_rd_i) begin
			if (!hit) begin
				n.rdata = 8'h00;
			end else begin
				case (sfr_addr_i)
					ADDR_CFG:     n.rdata = s_r.cfg;
					ADDR_RES_LO:  n.rdata = s_r.res_lo;
					ADDR_RES_HI:  n.rdata = s_r.res_hi;
					ADDR_UL_LOW:  n.rdata = s_r.gtl;
					ADDR_UL_HIGH: n.rdata = s_r.gth;
					ADDR_LL_LOW:  n.rdata = s_r.ltl;
					ADDR_LL_HIGH: n.rdata = s_r.lth;
					ADDR_CTL:     n.rdata = {s_r.en, s_r.tm, s_r.done,
						s_r.busy, s_r.cm, s_r.wint, s_r.ljst};
					default:      n.rdata = 8'h00;
				endcase
			end
		end
	end

	// state register; reset loads constants only
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_r <= '0;
			s_r.cfg <= RST_CFG;
			s_r.res_lo <= RST_RES;
			s_r.res_hi <= RST_RES;
			s_r.gth <= RST_UL;
			s_r.gtl <= RST_UL;
			s_r.lth <= RST_LL;
			s_r.ltl <= RST_LL;
			s_r.st <= ST_IDLE;
			s_r.gain <= GAIN_X1;
		end else begin
			s_r <= n;
		end
	end

	// outputs straight from the state register; sar tick straight from the divider
	assign sfr_rdata_o = s_r.rdata;
	assign adc_enable_o = s_r.en;
	assign track_o = s_r.track;
	assign conv_active_o = s_r.active;
	assign sar_tick_o = sar_tick;
	assign amp_gain_o = s_r.gain;
	assign conv_done_flag_o = s_r.done;
	assign window_match_flag_o = s_r.wint;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);

	a_sw_start: assert property (
		s_r.st == ST_IDLE && go_sw && n.en && !n.tm
		|=> s_r.busy && s_r.st == ST_CONV)
		else $error("busy write did not start");
	a_idle_stays: assert property (
		s_r.st == ST_IDLE && !start |=> !s_r.busy)
		else $error("busy set without a trigger");
	a_timer3_start: assert property (
		s_r.st == ST_IDLE && n.en && !n.tm && n.cm == SM_TIMER3 &&
		timer3_ovf_i |=> s_r.st == ST_CONV)
		else $error("timer 3 overflow ignored");
	a_track_three: assert property (
		$past(s_r.st) == ST_TRACK && s_r.st == ST_CONV
		|-> $past(s_r.cnt) == TRACK_LAST && $past(sar_tick))
		else $error("tracking not three sar clocks");
	a_pin_start: assert property (
		s_r.st == ST_IDLE && n.en && n.cm == SM_EXT_PIN && pin_rise
		|=> s_r.st == ST_CONV)
		else $error("pin edge did not convert");
	a_conv_len: assert property (
		$fell(s_r.busy) && s_r.en |-> $past(s_r.cnt) == CONV_LAST &&
		$past(sar_tick) && $past(s_r.st) == ST_CONV)
		else $error("conversion shorter than sixteen sar clocks");
	a_done_rise: assert property (
		$fell(s_r.busy) && s_r.en |-> $rose(s_r.done) || $past(s_r.done))
		else $error("done did not follow busy fall");
	a_done_hold: assert property (
		s_r.done && !done_clr |=> s_r.done)
		else $error("done cleared by hardware");
	a_wint_hold: assert property (
		s_r.wint && !wint_clr |=> s_r.wint)
		else $error("window flag cleared by hardware");
	a_win_set: assert property (
		cmpl && win_now |=> s_r.wint)
		else $error("window match not flagged");
	a_busy_state: assert property (
		s_r.busy == (s_r.st != ST_IDLE))
		else $error("busy disagrees with sequencer");
	a_shutdown: assert property (
		!s_r.en |-> !track_o && !s_r.busy && !conv_active_o)
		else $error("disabled converter active");
	a_cont_track: assert property (
		s_r.en && !s_r.tm |-> track_o == (s_r.st != ST_CONV))
		else $error("continuous tracking broken");
	a_left_just: assert property (
		cmpl && n.ljst |=> s_r.res_lo[3:0] == 4'h0 &&
		s_r.res_hi == $past(adc_data_i[11:4]))
		else $error("left justified result wrong");
	a_right_fill: assert property (
		cmpl && !n.ljst |=> s_r.res_hi[7:4] ==
		($past(diff_mode_i) ? {4{$past(adc_data_i[11])}} : 4'h0) &&
		{s_r.res_hi[3:0], s_r.res_lo} == $past(adc_data_i))
		else $error("right justified result wrong");

	c_low_power: cover property (cmpl && s_r.tm);
	c_window: cover property (cmpl && win_now);
	c_pin_conv: cover property (s_r.st == ST_IDLE && pin_rise && n.en);
	c_safe_div: cover property (cmpl && s_r.cfg[7:3] >= DIV_MIN_SAFE);
endmodule

// ==== include/sac_pkg.sv ====
/*
 * sac_pkg: shared constants and types for the converter control block.
 * Assumes one system clock at 25 MHz and an 8-bit special function
 * register bus on page 0.
 */
package sac_pkg;
	// register page and addresses
	localparam logic [7:0] SFR_PAGE_ADC  = 8'h00;
	localparam logic [7:0] ADDR_CFG      = 8'hbc;
	localparam logic [7:0] ADDR_RES_LO   = 8'hbe;
	localparam logic [7:0] ADDR_RES_HI   = 8'hbf;
	localparam logic [7:0] ADDR_UL_LOW   = 8'hc4;
	localparam logic [7:0] ADDR_UL_HIGH  = 8'hc5;
	localparam logic [7:0] ADDR_LL_LOW   = 8'hc6;
	localparam logic [7:0] ADDR_LL_HIGH  = 8'hc7;
	localparam logic [7:0] ADDR_CTL      = 8'he8;
	// values after reset
	localparam logic [7:0] RST_CFG       = 8'hf8;
	localparam logic [7:0] RST_RES       = 8'h00;
	localparam logic [7:0] RST_UL        = 8'hff;
	localparam logic [7:0] RST_LL        = 8'h00;
	// control register bit positions
	localparam int CTL_EN   = 7;
	localparam int CTL_TM   = 6;
	localparam int CTL_DONE = 5;
	localparam int CTL_BUSY = 4;
	localparam int CTL_CMH  = 3;
	localparam int CTL_CML  = 2;
	localparam int CTL_WINT = 1;
	localparam int CTL_LJST = 0;
	// start mode encodings
	localparam logic [1:0] SM_BUSY_WR = 2'h0;
	localparam logic [1:0] SM_TIMER3  = 2'h1;
	localparam logic [1:0] SM_EXT_PIN = 2'h2;
	localparam logic [1:0] SM_TIMER2  = 2'h3;
	// amplifier gain output codes
	localparam logic [2:0] GAIN_X1   = 3'h0;
	localparam logic [2:0] GAIN_X2   = 3'h1;
	localparam logic [2:0] GAIN_X4   = 3'h2;
	localparam logic [2:0] GAIN_X8   = 3'h3;
	localparam logic [2:0] GAIN_X16  = 3'h4;
	localparam logic [2:0] GAIN_X0P5 = 3'h5;
	// sar clock counts
	localparam logic [4:0] TRACK_LAST = 5'h02;
	localparam logic [4:0] CONV_LAST  = 5'h0f;
	// recommended sar clock ceiling and smallest safe divide value
	localparam int SYS_CLK_KHZ     = 25000;
	localparam int SAR_CLK_MAX_KHZ = 2500;
	localparam logic [4:0] DIV_MIN_SAFE =
		5'((SYS_CLK_KHZ + 2 * SAR_CLK_MAX_KHZ - 1)
		/ (2 * SAR_CLK_MAX_KHZ) - 1);
	// sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_CONV} sac_state_t;
endpackage

// ==== hw/sac_sar_div.sv ====
/*
 * sac_sar_div: divides the system clock into a one-cycle sar clock
 * enable. Assumes div_i and restart_i come from logic on the same clock.
 */
`timescale 1ns/100ps
module sac_sar_div
	import sac_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       rstn_i,
	// control
	input  wire logic [4:0] div_i,
	input  wire logic       restart_i,
	// sar clock enable
	output logic            tick_o
);
	typedef struct packed {
		logic [5:0] cnt;   // system clocks into the sar period
		logic       tick;  // one-cycle sar clock enable
	} sac_div_t;

	sac_div_t   s_r;
	sac_div_t   s_nxt;
	logic [5:0] lim;       // last count of a period

	// next state of the divider
	always_comb begin
		s_nxt = s_r;
		lim = {div_i, 1'b1};
		if (div_i == 5'h00) begin
			// full system rate, no division
			s_nxt.cnt = 6'h00;
			s_nxt.tick = 1'b1;
		end else if (restart_i) begin
			// realign the period to a new phase
			s_nxt.cnt = 6'h00;
			s_nxt.tick = 1'b0;
		end else begin
			// period of two times (div plus one) clocks
			s_nxt.tick = (s_r.cnt == lim);
			s_nxt.cnt = (s_r.cnt == lim) ? 6'h00 : s_r.cnt + 6'h01;
		end
	end

	// state register
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick_o = s_r.tick;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);

	a_full_rate: assert property (div_i == 5'h00 |=> tick_o)
		else $error("no tick at full rate");
	a_tick_gap: assert property (tick_o && div_i != 5'h00 |=> !tick_o)
		else $error("back to back ticks while dividing");
	a_div1_period: assert property (
		tick_o && div_i == 5'h01 && !restart_i ##1
		(div_i == 5'h01 && !restart_i) [*3] |=> tick_o)
		else $error("divide by one period is not four clocks");
endmodule

// ==== testbench/sac_adc_model.sv ====
/*
 * sac_adc_model: behavioural analog converter beside the control block.
 * Assumes the bench sets the code and input kind before each start.
 */
`timescale 1ns/100ps
module sac_adc_model (
	// clock
	input  wire logic        ref_clk_i,
	// control from the block
	input  wire logic        en_i,
	input  wire logic        active_i,
	// code chosen by the bench
	input  wire logic [11:0] code_i,
	input  wire logic        diff_i,
	// lines into the block
	output logic [11:0]      data_o,
	output logic             diff_o
);
	logic [11:0] last_r;  // last code put on the data lines

	// remember the last driven code
	always_ff @(posedge ref_clk_i) begin
		last_r <= data_o;
	end

	// code only while powered and converting, else a changing pattern
	always_comb begin
		if (en_i && active_i) begin
			data_o = code_i;
		end else begin
			data_o = ~last_r;
		end
	end
	assign diff_o = diff_i;
endmodule

// ==== testbench/tb.sv ====
/*
 * tb: self-checking bench for the converter control block.
 * Assumes sac_pkg and the partner model are compiled first.
 */
`timescale 1ns/100ps
module tb;
	import sac_pkg::*;
	logic        ref_clk_i, rstn_i, sfr_wr_i, sfr_rd_i, sfr_bit_wr_i;
	logic        sfr_bit_val_i, timer3_ovf_i, timer2_ovf_i, pin_i, diff_i;
	logic        diff_mode, adc_en, track_o, conv_active_o, sar_tick_o;
	logic        conv_done_flag_o, window_match_flag_o;
	logic [7:0]  sfr_page_i, sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
	logic [2:0]  sfr_bit_sel_i, amp_gain_o;
	logic [11:0] code_i, adc_data;
	int          bad_count, cmp_count;

	sac_ctrl DUT (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.sfr_page_i(sfr_page_i), .sfr_addr_i(sfr_addr_i),
		.sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
		.sfr_wdata_i(sfr_wdata_i), .sfr_bit_wr_i(sfr_bit_wr_i),
		.sfr_bit_sel_i(sfr_bit_sel_i), .sfr_bit_val_i(sfr_bit_val_i),
		.sfr_rdata_o(sfr_rdata_o), .timer3_ovf_i(timer3_ovf_i),
		.timer2_ovf_i(timer2_ovf_i), .ext_start_pin_i(pin_i),
		.adc_data_i(adc_data), .diff_mode_i(diff_mode),
		.adc_enable_o(adc_en), .track_o(track_o),
		.conv_active_o(conv_active_o), .sar_tick_o(sar_tick_o),
		.amp_gain_o(amp_gain_o), .conv_done_flag_o(conv_done_flag_o),
		.window_match_flag_o(window_match_flag_o));
	sac_adc_model PARTNER (.ref_clk_i(ref_clk_i), .en_i(adc_en),
		.active_i(conv_active_o), .code_i(code_i), .diff_i(diff_i),
		.data_o(adc_data), .diff_o(diff_mode));

	// 25 mhz system clock
	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	// compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// verdict and end of run
	task automatic close_out();
		$display("compares=%0d mismatches=%0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// byte write, one-cycle strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		sfr_addr_i <= a;
		sfr_wdata_i <= d;
		sfr_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		sfr_wr_i <= 1'b0;
	endtask

	// byte read, data registered on the taking edge, read at the falling edge after it
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		sfr_addr_i <= a;
		sfr_rd_i <= 1'b1;
		@(posedge ref_clk_i);
		sfr_rd_i <= 1'b0;
		@(negedge ref_clk_i);
		d = sfr_rdata_o;
	endtask

	// bit-addressed write to the control register
	task automatic bitw(input logic [2:0] s, input logic v);
		@(posedge ref_clk_i);
		sfr_bit_sel_i <= s;
		sfr_bit_val_i <= v;
		sfr_bit_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		sfr_bit_wr_i <= 1'b0;
	endtask

	// expected data word for a code
	function automatic logic [15:0] fmt(input logic [11:0] c,
		input logic d, input logic lj);
		return lj ? {c, 4'h0} : {{4{d & c[11]}}, c};
	endfunction

	// expected window flag from the limit order
	function automatic logic win(input logic [15:0] w, input logic [15:0] g,
		input logic [15:0] l, input logic s);
		logic a, b, i;
		a = s ? ($signed(w) > $signed(g)) : (w > g);
		b = s ? ($signed(w) < $signed(l)) : (w < l);
		i = s ? ($signed(l) > $signed(g)) : (l > g);
		return i ? (a && b) : (a || b);
	endfunction

	// configure, trigger, count sar ticks, wait for completion
	task automatic conv(input logic [7:0] ctl, output int cc, output int tc);
		logic pa;
		cc = 0;
		tc = 0;
		pa = 1'b0;
		@(posedge ref_clk_i);
		pin_i <= 1'b0;
		wr(ADDR_CTL, ctl);
		case (ctl[3:2])
			SM_TIMER3: begin
				timer3_ovf_i <= 1'b1;
				@(posedge ref_clk_i);
				timer3_ovf_i <= 1'b0;
			end
			SM_TIMER2: begin
				timer2_ovf_i <= 1'b1;
				@(posedge ref_clk_i);
				timer2_ovf_i <= 1'b0;
			end
			SM_EXT_PIN: begin
				repeat (6) @(negedge ref_clk_i);
				check(track_o, 1'b1);
				@(posedge ref_clk_i);
				pin_i <= 1'b1;
			end
			default: ;
		endcase
		repeat (2000) begin
			@(negedge ref_clk_i);
			if (conv_active_o) check(track_o, 1'b0);
			if (sar_tick_o && conv_active_o) cc++;
			if (sar_tick_o && track_o && ctl[6] && !conv_active_o) tc++;
			if (conv_done_flag_o === 1'b1) break;
			pa = conv_active_o;
		end
		check(conv_done_flag_o, 1'b1);
		check({pa, conv_active_o}, 16'h2);
	endtask

	// register reset values, unmapped place and foreign page
	task automatic t_reset();
		logic [7:0] aa[10] = '{ADDR_CFG, ADDR_RES_LO, ADDR_RES_HI,
			ADDR_UL_LOW, ADDR_UL_HIGH, ADDR_LL_LOW, ADDR_LL_HIGH,
			ADDR_CTL, 8'hc0, 8'hbd};
		logic [7:0] ev[10] = '{RST_CFG, RST_RES, RST_RES, RST_UL, RST_UL,
			RST_LL, RST_LL, 8'h00, 8'h00, 8'h00};
		logic [7:0] d;
		check(adc_en, 1'b0);
		for (int i = 0; i < 10; i++) begin
			rd(aa[i], d);
			check(d, ev[i]);
		end
		@(posedge ref_clk_i);
		sfr_page_i <= 8'h01;
		rd(ADDR_CFG, d);
		check(d, 8'h00);
		@(posedge ref_clk_i);
		sfr_page_i <= SFR_PAGE_ADC;
		$display("test reset values done");
	endtask

	// every gain code
	task automatic t_gain();
		logic [2:0] gx[8] = '{GAIN_X1, GAIN_X2, GAIN_X4, GAIN_X8, GAIN_X16,
			GAIN_X16, GAIN_X0P5, GAIN_X0P5};
		logic [7:0] d;
		for (int g = 0; g < 8; g++) begin
			wr(ADDR_CFG, {5'h1f, 3'(g)});
			rd(ADDR_CFG, d);
			check(d, {5'h1f, 3'(g)});
			check(amp_gain_o, gx[g]);
		end
		$display("test gain done");
	endtask

	// sar tick spacing for zero and nonzero divide
	task automatic t_div();
		logic [4:0] dv;
		int n;
		for (int i = 0; i < 2; i++) begin
			dv = (i == 0) ? 5'h00 : 5'h04;
			wr(ADDR_CFG, {dv, 3'h0});
			wr(ADDR_CTL, 8'h80);
			repeat (3) @(negedge ref_clk_i);
			check(adc_en, 1'b1);
			check(track_o, 1'b1);
			n = 0;
			while (sar_tick_o !== 1'b1 && n < 100) begin
				@(negedge ref_clk_i);
				n++;
			end
			n = 0;
			do begin
				@(negedge ref_clk_i);
				n++;
			end while (sar_tick_o !== 1'b1 && n < 100);
			check(16'(n), (dv == 0) ? 16'd1 : 16'(2 * (dv + 1)));
			wr(ADDR_CTL, 8'h00);
			repeat (2) @(negedge ref_clk_i);
			check(adc_en, 1'b0);
		end
		$display("test divider done");
	endtask

	// each trigger source, refused busy write, sticky done flag
	task automatic t_modes();
		logic [7:0] d;
		int cc, tc;
		wr(ADDR_CFG, 8'h00);
		@(posedge ref_clk_i);
		code_i <= 12'habc;
		diff_i <= 1'b0;
		wr(ADDR_CTL, 8'h94);
		repeat (40) @(negedge ref_clk_i);
		rd(ADDR_CTL, d);
		check(d, 8'h84);
		for (int i = 0; i < 4; i++) begin
			conv({4'h8, 2'(i), 2'b00} | ((i == 0) ? 8'h10 : 8'h00), cc, tc);
			check(16'(cc), 16'd16);
			rd(ADDR_RES_HI, d);
			check(d, 8'h0a);
			rd(ADDR_RES_LO, d);
			check(d, 8'hbc);
		end
		repeat (20) @(negedge ref_clk_i);
		check(conv_done_flag_o, 1'b1);
		bitw(3'(CTL_DONE), 1'b0);
		rd(ADDR_CTL, d);
		check(d, 8'h8c);
		bitw(3'(CTL_LJST), 1'b1);
		rd(ADDR_CTL, d);
		check(d, 8'h8d);
		$display("test start modes done");
	endtask

	// busy reads, low-power tracking and pin-paced tracking
	task automatic t_lowpow();
		logic [7:0] d;
		int cc, tc;
		wr(ADDR_CFG, 8'h08);
		wr(ADDR_CTL, 8'h90);
		rd(ADDR_CTL, d);
		check(d[4], 1'b1);
		repeat (300) begin
			@(negedge ref_clk_i);
			if (conv_done_flag_o === 1'b1) break;
		end
		rd(ADDR_CTL, d);
		check(d, 8'ha0);
		conv(8'hd0, cc, tc);
		check(16'(tc), 16'd3);
		check(16'(cc), 16'd16);
		conv(8'hc8, cc, tc);
		check(16'(cc), 16'd16);
		$display("test tracking done");
	endtask

	// justification and sign fill for both input kinds
	task automatic t_format();
		logic [7:0] h, l;
		logic [11:0] c;
		int cc, tc;
		wr(ADDR_CFG, 8'h00);
		for (int i = 0; i < 4; i++) begin
			c = i[1] ? 12'h800 : 12'habc;
			@(posedge ref_clk_i);
			code_i <= c;
			diff_i <= i[1];
			conv({7'h48, i[0]}, cc, tc);
			rd(ADDR_RES_HI, h);
			rd(ADDR_RES_LO, l);
			check({h, l}, fmt(c, i[1], i[0]));
		end
		$display("test justify done");
	endtask

	// window inside and outside, unsigned and signed, sticky flag
	task automatic t_window();
		logic [15:0] gt[7] = '{16'h0800, 16'h0800, 16'h0800, 16'h0100,
			16'h0100, 16'h0010, 16'h0010};
		logic [15:0] lt[7] = '{16'h0100, 16'h0100, 16'h0100, 16'h0800,
			16'h0800, 16'hfff0, 16'hfff0};
		logic [11:0] cd[7] = '{12'h900, 12'h050, 12'h400, 12'h400,
			12'h900, 12'hfff, 12'h020};
		logic e;
		int cc, tc;
		for (int i = 0; i < 7; i++) begin
			wr(ADDR_UL_HIGH, gt[i][15:8]);
			wr(ADDR_UL_LOW, gt[i][7:0]);
			wr(ADDR_LL_LOW, lt[i][7:0]);
			wr(ADDR_LL_HIGH, lt[i][15:8]);
			@(posedge ref_clk_i);
			code_i <= cd[i];
			diff_i <= (i > 4);
			conv(8'h90, cc, tc);
			e = win(fmt(cd[i], i > 4, 1'b0), gt[i], lt[i], i > 4);
			check(window_match_flag_o, e);
			repeat (10) @(negedge ref_clk_i);
			check(window_match_flag_o, e);
		end
		$display("test window done");
	endtask

	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		bad_count++;
		close_out();
	end

	// reset, then the scenarios
	initial begin
		bad_count = 0;
		cmp_count = 0;
		rstn_i = 1'b0;
		{sfr_wr_i, sfr_rd_i, sfr_bit_wr_i, sfr_bit_val_i} = 4'h0;
		{timer3_ovf_i, timer2_ovf_i, pin_i, diff_i} = 4'h0;
		sfr_page_i = SFR_PAGE_ADC;
		sfr_addr_i = 8'h00;
		sfr_wdata_i = 8'h00;
		sfr_bit_sel_i = 3'h0;
		code_i = 12'h000;
		repeat (5) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		t_reset();
		t_gain();
		t_div();
		t_modes();
		t_lowpow();
		t_format();
		t_window();
		close_out();
	end
endmodule
